// File: logic/fseei_params.svh
// Offsets, field positions, address limits and timing counts of the erase checker.
`ifndef FSEEI_PARAMS_SVH
`define FSEEI_PARAMS_SVH
`define FSEEI_OFF_CFG      12'h000
`define FSEEI_OFF_ERRCFG   12'h004
`define FSEEI_OFF_STAT     12'h008
`define FSEEI_OFF_ERRSTAT  12'h00C
`define FSEEI_OFF_CMD      12'h010
`define FSEEI_OFF_ADDR     12'h014
`define FSEEI_OFF_PROT     12'h018
`define FSEEI_OFF_MODE     12'h01C
`define FSEEI_CFG_COMMAND_COMPLETE_IRQ_ENABLE     0
`define FSEEI_ERR_SINGLE_FAULT_IRQ_ENABLE    0
`define FSEEI_ERR_DOUBLE_FAULT_IRQ_ENABLE    1
`define FSEEI_ST_VUNC      0
`define FSEEI_ST_VERR      1
`define FSEEI_ST_PVIOL     4
`define FSEEI_ST_ACCESS_ERROR_FLAG    5
`define FSEEI_ST_COMMAND_COMPLETE_FLAG      7
`define FSEEI_ES_SFD       0
`define FSEEI_ES_DFD       1
`define FSEEI_IDX_ERASE    3'h1
`define FSEEI_ADDR_LIMIT   18'h3FFFF
`define FSEEI_ADDR_BASE    18'h04000
`define FSEEI_ADDR_TOP     18'h04FFF
`define FSEEI_ERASE_NS     1000
`define FSEEI_CLK_MHZ      200
`define FSEEI_ERASE_CYC    ((`FSEEI_ERASE_NS * `FSEEI_CLK_MHZ) / 1000)
`endif

// File: logic/fseei_pkg.sv
// Types shared by the erase checker modules.
package fseei_pkg;
  typedef enum logic [1:0]
  {
    FSEEI_IDLE   = 2'b00,
    FSEEI_CHECK  = 2'b01,
    FSEEI_ERASE  = 2'b10,
    FSEEI_VERIFY = 2'b11
  } fseei_state_t;
endpackage : fseei_pkg

// File: logic/fseei_launch_if.sv
// Launch request and answer between the sequencer and the launch checker.
`timescale 1ns/10ps
interface fseei_launch_if;
  logic [2:0]  cmd_index;
  logic [17:0] gaddr;
  logic        mode_ok;
  logic [3:0]  prot_mask;
  logic        acc_err;
  logic        prot_err;
  modport seq (output cmd_index, output gaddr, output mode_ok,
               output prot_mask, input acc_err, input prot_err);
  modport chk (input cmd_index, input gaddr, input mode_ok,
               input prot_mask, output acc_err, output prot_err);
endinterface : fseei_launch_if

// File: logic/fseei_launch_check.sv
// Combinational launch checks for the sector-erase command.
`timescale 1ns/10ps
`include "fseei_params.svh"
module fseei_launch_check
(
  // Launch fields
  fseei_launch_if.chk lk
);
  import fseei_pkg::*;

  function automatic logic fseei_in_range(input logic [17:0] a);
    fseei_in_range = (a >= `FSEEI_ADDR_BASE) && (a <= `FSEEI_ADDR_TOP);
  endfunction : fseei_in_range

  logic [1:0] sector_q;

  assign sector_q = lk.gaddr[11:10];
  assign lk.acc_err = (lk.cmd_index != `FSEEI_IDX_ERASE)
                    || !lk.mode_ok
                    || !fseei_in_range(lk.gaddr)
                    || lk.gaddr[0];
  // Protection is judged on the quarter of the data area the sector lies in.
  assign lk.prot_err = lk.prot_mask[sector_q];
endmodule : fseei_launch_check

// File: logic/fseei_top.sv
// APB flash sector-erase sequencer with launch checks and interrupts.
// Functional notes
// - Index not one flags access error.
// - Erase unavailable in mode flags access error.
// - Invalid global address flags access error.
// - Odd address flags access error.
// - Protected target area flags protection violation.
// - Any verify error sets verify error bit.
// - Uncorrectable verify error sets uncorrectable bit.
// - Complete flag and enable raise command irq.
// - Either fault flag with enable raises error irq.
// - Double-bit read fault sets double fault flag.
// - Corrected single-bit fault sets single fault flag.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`include "fseei_params.svh"
module fseei_top
#(
  parameter int ERASE_CYC = `FSEEI_ERASE_CYC
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Flash array events
  input  wire logic        verify_err,
  input  wire logic        verify_uncorr,
  input  wire logic        read_double_fault,
  input  wire logic        read_single_fault,
  // Array control and interrupts
  output      logic        erase_active,
  output      logic        cmd_irq,
  output      logic        err_irq
);
  import fseei_pkg::*;

  typedef struct packed {
    fseei_state_t state;
    logic [15:0]  cnt;
    logic         command_complete_irq_enable;
    logic         single_fault_irq_enable;
    logic         double_fault_irq_enable;
    logic         command_complete_flag;
    logic         access_error_flag;
    logic         pviol;
    logic         verr;
    logic         vunc;
    logic         dfd;
    logic         sfd;
    logic [2:0]   cmd_index;
    logic [17:0]  gaddr;
    logic [3:0]   prot;
    logic         mode_ok;
    logic [31:0]  rdata;
  } fseei_regs_t;

  fseei_regs_t     st_r;
  fseei_regs_t     st_nxt;
  fseei_launch_if  lk ();
  logic            wr_en;
  logic            rd_en;
  logic            mapped;

  localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYC - 1);

  function automatic logic fseei_is_mapped(input logic [11:0] a);
    fseei_is_mapped = (a[1:0] == 2'h0) && (a <= `FSEEI_OFF_MODE);
  endfunction : fseei_is_mapped

  assign lk.cmd_index = st_r.cmd_index;
  assign lk.gaddr     = st_r.gaddr;
  assign lk.mode_ok   = st_r.mode_ok;
  assign lk.prot_mask = st_r.prot;

  fseei_launch_check u_chk
  (
    .lk (lk.chk)
  );

  // The slave answers in the first access cycle; no wait states.
  assign pready  = 1'b1;
  assign mapped  = fseei_is_mapped(paddr);
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && !penable && !pwrite;
  assign prdata  = st_r.rdata;

  assign erase_active = (st_r.state == FSEEI_ERASE);
  assign cmd_irq = st_r.command_complete_flag && st_r.command_complete_irq_enable;
  assign err_irq = (st_r.dfd && st_r.double_fault_irq_enable)
                 || (st_r.sfd && st_r.single_fault_irq_enable);

  always_comb
  begin
    st_nxt = st_r;
    if (wr_en)
    begin
      case (paddr)
        `FSEEI_OFF_CFG:
        begin
          st_nxt.command_complete_irq_enable = pwdata[`FSEEI_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
        end
        `FSEEI_OFF_ERRCFG:
        begin
          st_nxt.single_fault_irq_enable = pwdata[`FSEEI_ERR_SINGLE_FAULT_IRQ_ENABLE];
          st_nxt.double_fault_irq_enable = pwdata[`FSEEI_ERR_DOUBLE_FAULT_IRQ_ENABLE];
        end
        `FSEEI_OFF_STAT:
        begin
          // Write one to clear; launches only while idle.
          if (pwdata[`FSEEI_ST_ACCESS_ERROR_FLAG])
          begin
            st_nxt.access_error_flag = 1'b0;
          end
          if (pwdata[`FSEEI_ST_PVIOL])
          begin
            st_nxt.pviol = 1'b0;
          end
          if (pwdata[`FSEEI_ST_COMMAND_COMPLETE_FLAG] && st_r.state == FSEEI_IDLE)
          begin
            st_nxt.command_complete_flag  = 1'b0;
            st_nxt.verr  = 1'b0;
            st_nxt.vunc  = 1'b0;
            st_nxt.state = FSEEI_CHECK;
          end
        end
        `FSEEI_OFF_ERRSTAT:
        begin
          if (pwdata[`FSEEI_ES_DFD])
          begin
            st_nxt.dfd = 1'b0;
          end
          if (pwdata[`FSEEI_ES_SFD])
          begin
            st_nxt.sfd = 1'b0;
          end
        end
        `FSEEI_OFF_CMD:
        begin
          if (st_r.state == FSEEI_IDLE)
          begin
            st_nxt.cmd_index = pwdata[2:0];
          end
        end
        `FSEEI_OFF_ADDR:
        begin
          if (st_r.state == FSEEI_IDLE)
          begin
            st_nxt.gaddr = pwdata[17:0];
          end
        end
        `FSEEI_OFF_PROT:
        begin
          st_nxt.prot = pwdata[3:0];
        end
        `FSEEI_OFF_MODE:
        begin
          st_nxt.mode_ok = pwdata[0];
        end
        default:
        begin
          st_nxt.mode_ok = st_r.mode_ok;
        end
      endcase
    end
    // Hardware sets come after the clears so an event in a clear cycle wins.
    if (read_double_fault)
    begin
      st_nxt.dfd = 1'b1;
    end
    if (read_single_fault)
    begin
      st_nxt.sfd = 1'b1;
    end
    case (st_r.state)
      FSEEI_IDLE:
      begin
        st_nxt.cnt = 16'h0000;
      end
      FSEEI_CHECK:
      begin
        st_nxt.access_error_flag = st_nxt.access_error_flag | lk.acc_err;
        st_nxt.pviol  = st_nxt.pviol | lk.prot_err;
        if (lk.acc_err || lk.prot_err)
        begin
          st_nxt.command_complete_flag  = 1'b1;
          st_nxt.state = FSEEI_IDLE;
        end
        else
        begin
          st_nxt.state = FSEEI_ERASE;
        end
      end
      FSEEI_ERASE:
      begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
        if (st_r.cnt >= ERASE_LAST)
        begin
          st_nxt.cnt   = 16'h0000;
          st_nxt.state = FSEEI_VERIFY;
        end
      end
      FSEEI_VERIFY:
      begin
        st_nxt.verr  = verify_err || verify_uncorr;
        st_nxt.vunc  = verify_uncorr;
        st_nxt.command_complete_flag  = 1'b1;
        st_nxt.state = FSEEI_IDLE;
      end
      default:
      begin
        st_nxt.state = FSEEI_IDLE;
      end
    endcase
    if (rd_en)
    begin
      case (paddr)
        `FSEEI_OFF_CFG:
          st_nxt.rdata = {31'h0, st_r.command_complete_irq_enable};
        `FSEEI_OFF_ERRCFG:
          st_nxt.rdata = {30'h0, st_r.double_fault_irq_enable, st_r.single_fault_irq_enable};
        `FSEEI_OFF_STAT:
          st_nxt.rdata = {24'h0, st_r.command_complete_flag, 1'b0, st_r.access_error_flag, st_r.pviol,
                          2'h0, st_r.verr, st_r.vunc};
        `FSEEI_OFF_ERRSTAT:
          st_nxt.rdata = {30'h0, st_r.dfd, st_r.sfd};
        `FSEEI_OFF_CMD:
          st_nxt.rdata = {29'h0, st_r.cmd_index};
        `FSEEI_OFF_ADDR:
          st_nxt.rdata = {14'h0, st_r.gaddr};
        `FSEEI_OFF_PROT:
          st_nxt.rdata = {28'h0, st_r.prot};
        `FSEEI_OFF_MODE:
          st_nxt.rdata = {31'h0, st_r.mode_ok};
        default:
          st_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r         <= '0;
      st_r.command_complete_flag    <= 1'b1;
      st_r.mode_ok <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  sequence s_launch_bad;
    st_r.state == FSEEI_CHECK && lk.acc_err;
  endsequence

  AST_ACC_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_launch_bad |=> st_r.access_error_flag)
    else $error("Access error not set after bad launch.");
  AST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && !st_r.mode_ok |=> st_r.access_error_flag)
    else $error("Mode fault not flagged.");
  AST_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && st_r.gaddr > `FSEEI_ADDR_TOP
    |=> st_r.access_error_flag)
    else $error("Out of range address not flagged.");
  AST_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && st_r.gaddr[0] |=> st_r.access_error_flag)
    else $error("Odd address not flagged.");
  AST_PROT: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && lk.prot_err |=> st_r.pviol)
    else $error("Protection violation not flagged.");
  AST_VERR: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_VERIFY && verify_err |=> st_r.verr && st_r.command_complete_flag)
    else $error("Verify error not reported.");
  AST_VUNC: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_VERIFY |=> st_r.vunc == $past(verify_uncorr))
    else $error("Uncorrectable bit wrong.");
  AST_CMDIRQ: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_irq == (st_r.command_complete_flag && st_r.command_complete_irq_enable))
    else $error("Command irq mismatch.");
  AST_ERRIRQ: assert property (@(posedge pclk) disable iff (!presetn)
    read_double_fault && st_r.double_fault_irq_enable |=> err_irq)
    else $error("Error irq missing after fault.");
  AST_DFD: assert property (@(posedge pclk) disable iff (!presetn)
    read_double_fault |=> st_r.dfd)
    else $error("Double fault flag not set.");
  AST_SFD: assert property (@(posedge pclk) disable iff (!presetn)
    read_single_fault |=> st_r.sfd)
    else $error("Single fault flag not set.");
  AST_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
    s_launch_bad |=> st_r.state == FSEEI_IDLE && st_r.command_complete_flag && !erase_active)
    else $error("Erase not skipped after launch error.");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.access_error_flag && !wr_en |=> st_r.access_error_flag)
    else $error("Access error dropped without clear.");

  // A clean launch must reach the erase phase; only launch errors skip it.
  sequence s_launch_good;
    st_r.state == FSEEI_CHECK && !lk.acc_err && !lk.prot_err;
  endsequence

  AST_GO: assert property (@(posedge pclk) disable iff (!presetn)
    s_launch_good |=> erase_active && !st_r.command_complete_flag)
    else $error("Clean launch did not start the erase.");
  AST_PSKIP: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && lk.prot_err
    |=> st_r.command_complete_flag && !erase_active)
    else $error("Erase not skipped after protection fault.");
  AST_IDX: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && st_r.cmd_index != `FSEEI_IDX_ERASE
    |=> st_r.access_error_flag)
    else $error("Wrong command index not flagged.");
  AST_LOWADR: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_CHECK && st_r.gaddr < `FSEEI_ADDR_BASE
    |=> st_r.access_error_flag)
    else $error("Address below data area not flagged.");
  AST_VANY: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_VERIFY && verify_uncorr |=> st_r.verr)
    else $error("Uncorrectable error not counted as verify error.");
  AST_VCLEAN: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.state == FSEEI_VERIFY && !verify_err && !verify_uncorr
    |=> !st_r.verr && !st_r.vunc)
    else $error("Verify bits set after clean verify.");
  AST_SIRQ: assert property (@(posedge pclk) disable iff (!presetn)
    read_single_fault && st_r.single_fault_irq_enable |=> err_irq)
    else $error("Error irq missing after single fault.");
  AST_PVHOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.pviol && !wr_en |=> st_r.pviol)
    else $error("Protection flag dropped without clear.");
  AST_DFHOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.dfd && !wr_en |=> st_r.dfd)
    else $error("Double fault flag dropped without clear.");
  AST_SFHOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.sfd && !wr_en |=> st_r.sfd)
    else $error("Single fault flag dropped without clear.");
endmodule : fseei_top

// File: verification/fseei_array_model.sv
// Flash array model that answers erase verify and raises read faults.
`timescale 1ns/10ps
module fseei_array_model
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Array side
  input  wire logic       erase_active,
  input  wire logic [1:0] vmode,
  output      logic       verify_err,
  output      logic       verify_uncorr,
  output      logic       read_double_fault,
  output      logic       read_single_fault
);
  logic busy_r;
  logic tog_r;
  // Outside an erase and the cycle after it the verify lines toggle, so a late sample shows up.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r <= 1'b0;
      tog_r  <= 1'b0;
    end
    else
    begin
      busy_r <= erase_active;
      tog_r  <= ~tog_r;
    end
  end
  assign verify_err    = (erase_active | busy_r) ? vmode[1] : tog_r;
  assign verify_uncorr = (erase_active | busy_r) ? vmode[0] : ~tog_r;
  initial
  begin
    read_double_fault = 1'b0;
    read_single_fault = 1'b0;
  end
  task automatic fault(input logic dbl);
    @(posedge pclk);
    read_double_fault <= dbl;
    read_single_fault <= ~dbl;
    @(posedge pclk);
    read_double_fault <= 1'b0;
    read_single_fault <= 1'b0;
  endtask : fault
endmodule : fseei_array_model

// File: verification/flash_sector_erase_error_irq_test.sv
// Self-checking bench for the sector-erase checker.
`timescale 1ns/10ps
`include "fseei_params.svh"
module flash_sector_erase_error_irq_test;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        verify_err, verify_uncorr, dfault, sfault;
  logic        erase_active, cmd_irq, err_irq, er_seen;
  logic [1:0]  vmode;
  int          fails, num_checks, polls;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (erase_active === 1'b1) er_seen = 1'b1;
  fseei_top #(.ERASE_CYC(4)) i_fseei_top
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .verify_err(verify_err),
    .verify_uncorr(verify_uncorr), .read_double_fault(dfault),
    .read_single_fault(sfault), .erase_active(erase_active),
    .cmd_irq(cmd_irq), .err_irq(err_irq)
  );
  fseei_array_model i_fseei_array_model
  (
    .pclk(pclk), .presetn(presetn), .erase_active(erase_active),
    .vmode(vmode), .verify_err(verify_err), .verify_uncorr(verify_uncorr),
    .read_double_fault(dfault), .read_single_fault(sfault)
  );
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Leaves the final status word in rd once the complete flag is back.
  task automatic launch(input logic [2:0] idx, input logic [17:0] adr);
    apb(1'b1, `FSEEI_OFF_CMD, {29'h0, idx});
    apb(1'b1, `FSEEI_OFF_ADDR, {14'h0, adr});
    er_seen = 1'b0;
    apb(1'b1, `FSEEI_OFF_STAT, 32'h80);
    for (polls = 1; polls <= 40; polls++)
    begin
      apb(1'b0, `FSEEI_OFF_STAT, 32'h0);
      if (rd[7] === 1'b1)
        break;
    end
    if (polls > 40)
    begin
      fails++;
      end_of_test();
    end
  endtask : launch
  task automatic t_index();
    for (int i = 0; i < 8; i++)
    begin
      launch(i[2:0], 18'h04000);
      chk(rd, (i == 1) ? 32'h80 : 32'hA0);
      chk({31'h0, er_seen}, {31'h0, i == 1});
      if (i != 1)
        chk(polls, 1);
      apb(1'b1, `FSEEI_OFF_STAT, 32'h30);
    end
  endtask : t_index
  task automatic t_addr();
    logic [17:0] adr [4] = '{18'h03FFE, 18'h05000, 18'h04001, 18'h04FFE};
    logic [31:0] exp [4] = '{32'hA0, 32'hA0, 32'hA0, 32'h80};
    for (int k = 0; k < 4; k++)
    begin
      launch(3'h1, adr[k]);
      chk(rd, exp[k]);
      apb(1'b1, `FSEEI_OFF_STAT, 32'h30);
    end
  endtask : t_addr
  task automatic t_mode();
    apb(1'b1, `FSEEI_OFF_MODE, 32'h0);
    launch(3'h1, 18'h04000);
    chk(rd, 32'hA0);
    apb(1'b0, `FSEEI_OFF_STAT, 32'h0);
    chk(rd, 32'hA0);
    apb(1'b1, `FSEEI_OFF_STAT, 32'h30);
    apb(1'b0, `FSEEI_OFF_STAT, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, `FSEEI_OFF_MODE, 32'h1);
    launch(3'h1, 18'h04000);
    chk(rd, 32'h80);
  endtask : t_mode
  task automatic t_prot();
    for (int q = 0; q < 4; q++)
    begin
      apb(1'b1, `FSEEI_OFF_PROT, 32'h1 << q);
      launch(3'h1, 18'h04000 | 18'(q << 10));
      chk(rd, 32'h90);
      apb(1'b1, `FSEEI_OFF_STAT, 32'h30);
      launch(3'h1, 18'h04000 | 18'(((q + 1) % 4) << 10));
      chk(rd, 32'h80);
    end
    apb(1'b1, `FSEEI_OFF_PROT, 32'h0);
  endtask : t_prot
  task automatic t_verify();
    logic [1:0]  m [4]   = '{2'b00, 2'b10, 2'b11, 2'b01};
    logic [31:0] exp [4] = '{32'h80, 32'h82, 32'h83, 32'h83};
    for (int k = 0; k < 4; k++)
    begin
      vmode <= m[k];
      launch(3'h1, 18'h04002);
      chk(rd, exp[k]);
    end
    vmode <= 2'b00;
  endtask : t_verify
  task automatic t_irq();
    apb(1'b1, `FSEEI_OFF_CFG, 32'h1);
    @(negedge pclk);
    chk({31'h0, cmd_irq}, 32'h1);
    apb(1'b1, `FSEEI_OFF_CFG, 32'h0);
    @(negedge pclk);
    chk({31'h0, cmd_irq}, 32'h0);
    apb(1'b1, `FSEEI_OFF_ERRCFG, 32'h3);
    i_fseei_array_model.fault(1'b1);
    apb(1'b0, `FSEEI_OFF_ERRSTAT, 32'h0);
    chk(rd, 32'h2);
    @(negedge pclk);
    chk({31'h0, err_irq}, 32'h1);
    apb(1'b1, `FSEEI_OFF_ERRCFG, 32'h1);
    @(negedge pclk);
    chk({31'h0, err_irq}, 32'h0);
    i_fseei_array_model.fault(1'b0);
    apb(1'b0, `FSEEI_OFF_ERRSTAT, 32'h0);
    chk(rd, 32'h3);
    @(negedge pclk);
    chk({31'h0, err_irq}, 32'h1);
    apb(1'b1, `FSEEI_OFF_ERRSTAT, 32'h2);
    apb(1'b0, `FSEEI_OFF_ERRSTAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `FSEEI_OFF_ERRSTAT, 32'h1);
    @(negedge pclk);
    chk({31'h0, err_irq}, 32'h0);
  endtask : t_irq
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vmode = 2'b00;
    er_seen = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FSEEI_OFF_STAT, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk(rd, 32'h0);
    t_index();
    t_addr();
    t_mode();
    t_prot();
    t_verify();
    t_irq();
    end_of_test();
  end
endmodule : flash_sector_erase_error_irq_test
